// ---- rtl/osc_cfg_pkg.sv ----
package osc_cfg_pkg;
  // system clock source codes
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_DIVN = 3'h7;
  // primary oscillator modes
  localparam logic [1:0] PMODE_EXT_CLOCK = 2'h0;
  localparam logic [1:0] PMODE_CRYSTAL = 2'h1;
  localparam logic [1:0] PMODE_HIGH_SPEED = 2'h2;
  localparam logic [1:0] PMODE_OFF = 2'h3;
  // switch and monitor modes
  localparam logic [1:0] SWMON_BOTH_ON = 2'h0;
  localparam logic [1:0] SWMON_SWITCH_ONLY = 2'h1;
  // source select config word fields
  localparam int SEL_SRC_LSB = 0;
  localparam int SEL_TWO_SPEED_BIT = 7;
  // oscillator config word fields
  localparam int OSC_MODE_LSB = 0;
  localparam int OSC_PIN_FN_BIT = 2;
  localparam int OSC_ONE_WAY_BIT = 5;
  localparam int OSC_SWMON_LSB = 6;
  // register indices
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_DIVISOR = 3'h1;
  localparam logic [2:0] ADDR_FEEDBACK = 3'h2;
  localparam logic [2:0] ADDR_TUNING = 3'h3;
  localparam logic [2:0] ADDR_AUX = 3'h4;
  localparam logic [2:0] ADDR_SEL_WORD = 3'h5;
  localparam logic [2:0] ADDR_OSC_WORD = 3'h6;
  // control register fields
  localparam int CTL_CUR_LSB = 12;
  localparam int CTL_NEW_LSB = 8;
  localparam int CTL_CLK_LOCK = 7;
  localparam int CTL_IO_LOCK = 6;
  localparam int CTL_PLL_LOCK = 5;
  localparam int CTL_FAIL = 3;
  localparam int CTL_SEC_EN = 1;
  localparam int CTL_SWITCH_REQ = 0;
  // divisor register fields
  localparam int DIV_ROI_BIT = 15;
  localparam int DIV_DOZE_LSB = 12;
  localparam int DIV_DOZE_EN_BIT = 11;
  localparam int DIV_FRC_LSB = 8;
  localparam int DIV_POST_LSB = 6;
  localparam int DIV_PRE_LSB = 0;
  localparam logic [15:0] DIV_WRITE_MASK = 16'hffdf;
  // aux control fields
  localparam int AUX_MODE_LSB = 0;
  localparam int AUX_DIV_LSB = 2;
  // values after power-on reset
  localparam logic [15:0] DIVISOR_RESET = 16'h3040;
  localparam logic [8:0] FEEDBACK_RESET = 9'h030;
  localparam logic [5:0] TUNING_RESET = 6'h00;
  localparam logic [4:0] AUX_RESET = 5'h00;

  typedef enum logic [1:0] {
    ST_CAPTURE,
    ST_START,
    ST_RUN,
    ST_SWITCH
  } sw_state_t;
endpackage

// ---- rtl/oscillator_source_config.sv ----
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - at power-on the system clock comes from the initial source field.
// - initial source codes 000..111 map to the eight clock sources.
// - an erased device starts on fast RC through the divide-by-N stage.
// - after power-on, sources change only by the clock-switch mechanism or a fail monitor fallback to fast RC.
// - primary mode 11 off, 10 high-speed crystal, 01 crystal, 00 ext clock.
// - pin function bit one drives cycle clock out, zero leaves GPIO.
// - pin function bit ignored in crystal and high-speed crystal modes.
// - two-speed start runs fast RC first, then moves to chosen source.
// - switch mode 1x both off, 01 switching only, 00 both on.
// - one-way bit set allows one pin remap lock, else unlimited.
// - config words live in program memory, set only when programming.
// - primary codes combine with primary mode to pick crystal or clock.
// - run-time oscillator registers reset on power-on reset only.
// - control register handles switching, reports source, lock, failure.
// - divisor register holds doze, PLL pre/post and fast RC postscale.
// - tuning register trims fast RC frequency over a symmetric range.
// - aux clock register selects aux oscillator mode and divider.
// - instruction cycle clock is the system clock divided by two.
// - switch request bit starts a switch to new source, clears when done.
// - read-only current source field uses the initial source encoding.
module oscillator_source_config #(
  parameter int AddrWidth = 3
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // nonvolatile configuration words
  input wire logic [15:0] srcSelectCfgWord,
  input wire logic [15:0] oscCfgWord,
  // register port
  input wire logic [AddrWidth-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // oscillator status from the analog side
  input wire logic primaryReadyPin,
  input wire logic secondaryReadyPin,
  input wire logic pllLockPin,
  input wire logic clockFailPin,
  // interrupt event for doze recovery
  input wire logic intEvent,
  // clock tree controls
  output logic [2:0] activeSource,
  output logic [1:0] primaryMode,
  output logic primaryEnable,
  output logic pllEnable,
  output logic secondaryEnable,
  output logic failMonitorEnable,
  output logic switchEnabled,
  output logic dozeEnable,
  output logic [2:0] dozeRatio,
  output logic [2:0] frcPostscale,
  output logic [4:0] pllPrescale,
  output logic [1:0] pllPostscale,
  output logic [8:0] pllFeedback,
  output logic [5:0] rcTune,
  output logic [1:0] auxMode,
  output logic [2:0] auxDivide,
  output logic pinSelectWriteOk,
  output logic cfgReady,
  // instruction clock pin
  output logic oscPinOut,
  output logic oscPinOe,
  output logic oscPinIsGpio
);
  initial begin
    if (AddrWidth < 3) $error("AddrWidth must be at least 3");
  end
  function automatic logic usesPll(input logic [2:0] src);
    usesPll = (src == osc_cfg_pkg::SRC_FAST_RC_PLL) ||
              (src == osc_cfg_pkg::SRC_PRIMARY_PLL);
  endfunction
  function automatic logic usesPrimary(input logic [2:0] src);
    usesPrimary = (src == osc_cfg_pkg::SRC_PRIMARY) ||
                  (src == osc_cfg_pkg::SRC_PRIMARY_PLL);
  endfunction
  // analog status, two flops before use
  logic [3:0] statMeta_ff;
  logic [3:0] statSync_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statMeta_ff <= 4'h0;
      statSync_ff <= 4'h0;
    end else begin
      statMeta_ff <= {clockFailPin, pllLockPin, secondaryReadyPin,
                      primaryReadyPin};
      statSync_ff <= statMeta_ff;
    end
  end
  wire priReady = statSync_ff[0];
  wire secReady = statSync_ff[1];
  wire pllLocked = statSync_ff[2];
  wire clkFailed = statSync_ff[3];
  // config words caught after reset release, never from a port under reset
  osc_cfg_pkg::sw_state_t state_ff;
  osc_cfg_pkg::sw_state_t nxt_state;
  logic [15:0] selWord_ff;
  logic [15:0] oscWord_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selWord_ff <= 16'hffff;
      oscWord_ff <= 16'hffff;
    end else if (state_ff == osc_cfg_pkg::ST_CAPTURE) begin
      selWord_ff <= srcSelectCfgWord;
      oscWord_ff <= oscCfgWord;
    end
  end
  // config decode
  wire [2:0] initSrc = selWord_ff[osc_cfg_pkg::SEL_SRC_LSB +: 3];
  wire twoSpeed = selWord_ff[osc_cfg_pkg::SEL_TWO_SPEED_BIT];
  wire [1:0] priMode = oscWord_ff[osc_cfg_pkg::OSC_MODE_LSB +: 2];
  wire pinFunction = oscWord_ff[osc_cfg_pkg::OSC_PIN_FN_BIT];
  wire oneWay = oscWord_ff[osc_cfg_pkg::OSC_ONE_WAY_BIT];
  wire [1:0] swMon = oscWord_ff[osc_cfg_pkg::OSC_SWMON_LSB +: 2];
  wire crystalMode = (priMode == osc_cfg_pkg::PMODE_CRYSTAL) ||
                     (priMode == osc_cfg_pkg::PMODE_HIGH_SPEED);
  wire priUsable = priMode != osc_cfg_pkg::PMODE_OFF;
  wire cfgSwitchOk = !swMon[1];
  wire monitorOn = swMon == osc_cfg_pkg::SWMON_BOTH_ON;
  // register bank
  logic [2:0] curSrc_ff;
  logic [2:0] target_ff;
  logic [2:0] newSrc_ff;
  logic switchReq_ff;
  logic clkLock_ff;
  logic ioLock_ff;
  logic fail_ff;
  logic secEn_ff;
  logic [15:0] divisor_ff;
  logic [8:0] feedback_ff;
  logic [5:0] tuning_ff;
  logic [4:0] aux_ff;
  logic [15:0] rdData_ff;
  logic fcyPhase_ff;
  // clock lock only counts with switching on and monitor off
  wire clkLockOn = clkLock_ff && (swMon == osc_cfg_pkg::SWMON_SWITCH_ONLY);
  wire switchOk = cfgSwitchOk && !clkLockOn;
  function automatic logic srcReady(input logic [2:0] src,
                                    input logic pri, input logic sec,
                                    input logic lock, input logic priOn);
    logic rdy;
    rdy = 1'b1;
    if (usesPrimary(src)) rdy = pri && priOn;
    if (src == osc_cfg_pkg::SRC_SECONDARY) rdy = sec;
    if (usesPll(src)) rdy = rdy && lock;
    srcReady = rdy;
  endfunction
  // address decode
  wire addrHiZero = (regAddr >> 3) == '0;
  wire [2:0] addrLo = regAddr[2:0];
  wire wrCtl = regWr && addrHiZero && addrLo == osc_cfg_pkg::ADDR_CONTROL;
  wire wrDiv = regWr && addrHiZero && addrLo == osc_cfg_pkg::ADDR_DIVISOR;
  wire wrFbd = regWr && addrHiZero && addrLo == osc_cfg_pkg::ADDR_FEEDBACK;
  wire wrTun = regWr && addrHiZero && addrLo == osc_cfg_pkg::ADDR_TUNING;
  wire wrAux = regWr && addrHiZero && addrLo == osc_cfg_pkg::ADDR_AUX;
  // switching sequencer
  wire targetReady = srcReady(target_ff, priReady, secReady, pllLocked,
                              priUsable);
  wire failTake = monitorOn && clkFailed &&
                  curSrc_ff != osc_cfg_pkg::SRC_FAST_RC &&
                  (state_ff == osc_cfg_pkg::ST_RUN ||
                   state_ff == osc_cfg_pkg::ST_SWITCH);
  wire startTwoSpeed = twoSpeed && initSrc != osc_cfg_pkg::SRC_FAST_RC;
  logic [2:0] nxt_curSrc;
  logic [2:0] nxt_target;
  logic reqDone;
  always_comb begin
    nxt_state = state_ff;
    nxt_curSrc = curSrc_ff;
    nxt_target = target_ff;
    reqDone = 1'b0;
    unique case (state_ff)
      osc_cfg_pkg::ST_CAPTURE: begin
        nxt_state = osc_cfg_pkg::ST_START;
      end
      osc_cfg_pkg::ST_START: begin
        nxt_target = initSrc;
        if (startTwoSpeed) begin
          nxt_curSrc = osc_cfg_pkg::SRC_FAST_RC;
          nxt_state = osc_cfg_pkg::ST_SWITCH;
        end else begin
          nxt_curSrc = initSrc;
          nxt_state = osc_cfg_pkg::ST_RUN;
        end
      end
      osc_cfg_pkg::ST_RUN: begin
        if (switchReq_ff) begin
          reqDone = 1'b1; // dropped when locked
          if (switchOk) begin
            reqDone = 1'b0;
            nxt_target = newSrc_ff;
            nxt_state = osc_cfg_pkg::ST_SWITCH;
          end
        end
      end
      osc_cfg_pkg::ST_SWITCH: begin
        if (targetReady) begin
          nxt_curSrc = target_ff;
          reqDone = 1'b1;
          nxt_state = osc_cfg_pkg::ST_RUN;
        end
      end
    endcase
    if (failTake) begin
      // monitor falls back to fast RC and abandons any switch
      nxt_curSrc = osc_cfg_pkg::SRC_FAST_RC;
      reqDone = 1'b1;
      nxt_state = osc_cfg_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= osc_cfg_pkg::ST_CAPTURE;
      curSrc_ff <= osc_cfg_pkg::SRC_FAST_RC_DIVN;
      target_ff <= osc_cfg_pkg::SRC_FAST_RC_DIVN;
    end else begin
      state_ff <= nxt_state;
      curSrc_ff <= nxt_curSrc;
      target_ff <= nxt_target;
    end
  end
  // control register; software writes win over hardware clears
  wire nxt_switchReq = wrCtl ? regWrData[osc_cfg_pkg::CTL_SWITCH_REQ] :
                       (reqDone ? 1'b0 : switchReq_ff);
  wire nxt_ioLock = wrCtl ? (regWrData[osc_cfg_pkg::CTL_IO_LOCK] |
                             (oneWay & ioLock_ff)) : ioLock_ff;
  wire nxt_fail = failTake ||
                  (fail_ff && !(wrCtl && !regWrData[osc_cfg_pkg::CTL_FAIL]));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      newSrc_ff <= osc_cfg_pkg::SRC_FAST_RC_DIVN;
      switchReq_ff <= 1'b0;
      clkLock_ff <= 1'b0;
      ioLock_ff <= 1'b0;
      fail_ff <= 1'b0;
      secEn_ff <= 1'b0;
    end else begin
      if (state_ff == osc_cfg_pkg::ST_START) begin
        newSrc_ff <= initSrc;
      end else if (wrCtl) begin
        newSrc_ff <= regWrData[osc_cfg_pkg::CTL_NEW_LSB +: 3];
      end
      switchReq_ff <= nxt_switchReq;
      clkLock_ff <= clkLock_ff | (wrCtl & regWrData[osc_cfg_pkg::CTL_CLK_LOCK]);
      ioLock_ff <= nxt_ioLock;
      fail_ff <= nxt_fail;
      if (wrCtl) begin
        secEn_ff <= regWrData[osc_cfg_pkg::CTL_SEC_EN];
      end
    end
  end
  // divisor, feedback, tuning and aux registers; power-on reset only
  wire roiOn = divisor_ff[osc_cfg_pkg::DIV_ROI_BIT];
  wire [15:0] divWritten = wrDiv ? (regWrData & osc_cfg_pkg::DIV_WRITE_MASK)
                                 : divisor_ff;
  // an interrupt beats a same-cycle write that would set doze again
  wire [15:0] nxt_divisor = (intEvent && roiOn) ?
      (divWritten & ~(16'h0001 << osc_cfg_pkg::DIV_DOZE_EN_BIT)) : divWritten;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divisor_ff <= osc_cfg_pkg::DIVISOR_RESET;
      feedback_ff <= osc_cfg_pkg::FEEDBACK_RESET;
      tuning_ff <= osc_cfg_pkg::TUNING_RESET;
      aux_ff <= osc_cfg_pkg::AUX_RESET;
    end else begin
      divisor_ff <= nxt_divisor;
      if (wrFbd) feedback_ff <= regWrData[8:0];
      if (wrTun) tuning_ff <= regWrData[5:0];
      if (wrAux) aux_ff <= regWrData[4:0];
    end
  end
  // read path, data valid the cycle after the strobe
  wire [15:0] ctlView = {1'b0, curSrc_ff, 1'b0, newSrc_ff, clkLock_ff,
                         ioLock_ff, pllLocked, 1'b0, fail_ff, 1'b0, secEn_ff,
                         switchReq_ff};
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    if (addrHiZero) begin
      unique case (addrLo)
        osc_cfg_pkg::ADDR_CONTROL: rdMux = ctlView;
        osc_cfg_pkg::ADDR_DIVISOR: rdMux = divisor_ff;
        osc_cfg_pkg::ADDR_FEEDBACK: rdMux = {7'h00, feedback_ff};
        osc_cfg_pkg::ADDR_TUNING: rdMux = {10'h000, tuning_ff};
        osc_cfg_pkg::ADDR_AUX: rdMux = {11'h000, aux_ff};
        osc_cfg_pkg::ADDR_SEL_WORD: rdMux = selWord_ff;
        osc_cfg_pkg::ADDR_OSC_WORD: rdMux = oscWord_ff;
        default: rdMux = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 16'h0000;
    end else if (regRd) begin
      rdData_ff <= rdMux;
    end else begin
      rdData_ff <= 16'h0000;
    end
  end
  // cycle clock: half the system clock rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcyPhase_ff <= 1'b0;
    end else begin
      fcyPhase_ff <= ~fcyPhase_ff;
    end
  end

  wire running = state_ff == osc_cfg_pkg::ST_RUN ||
                 state_ff == osc_cfg_pkg::ST_SWITCH;
  // pin belongs to the crystal in crystal modes
  wire pinDrive = running && pinFunction && !crystalMode;
  wire inSwitch = state_ff == osc_cfg_pkg::ST_SWITCH;

  assign regRdData = rdData_ff;
  assign activeSource = curSrc_ff;
  assign primaryMode = priMode;
  assign primaryEnable = priUsable && (usesPrimary(curSrc_ff) ||
                         (inSwitch && usesPrimary(target_ff)));
  assign pllEnable = usesPll(curSrc_ff) ||
                     (inSwitch && usesPll(target_ff));
  assign secondaryEnable = secEn_ff ||
                           curSrc_ff == osc_cfg_pkg::SRC_SECONDARY;
  assign failMonitorEnable = monitorOn && running;
  assign switchEnabled = switchOk;
  assign dozeEnable = divisor_ff[osc_cfg_pkg::DIV_DOZE_EN_BIT];
  assign dozeRatio = divisor_ff[osc_cfg_pkg::DIV_DOZE_LSB +: 3];
  assign frcPostscale = divisor_ff[osc_cfg_pkg::DIV_FRC_LSB +: 3];
  assign pllPrescale = divisor_ff[osc_cfg_pkg::DIV_PRE_LSB +: 5];
  assign pllPostscale = divisor_ff[osc_cfg_pkg::DIV_POST_LSB +: 2];
  assign pllFeedback = feedback_ff;
  assign rcTune = tuning_ff;
  assign auxMode = aux_ff[osc_cfg_pkg::AUX_MODE_LSB +: 2];
  assign auxDivide = aux_ff[osc_cfg_pkg::AUX_DIV_LSB +: 3];
  assign pinSelectWriteOk = !ioLock_ff;
  assign cfgReady = running;
  assign oscPinOut = fcyPhase_ff;
  assign oscPinOe = pinDrive;
  assign oscPinIsGpio = running && !pinFunction && !crystalMode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_direct: assert property (
    state_ff == osc_cfg_pkg::ST_START && !startTwoSpeed
    |=> activeSource == $past(initSrc) && state_ff == osc_cfg_pkg::ST_RUN)
    else $error("start source differs from config");
  chk_two_speed_start: assert property (
    state_ff == osc_cfg_pkg::ST_START && startTwoSpeed
    |=> activeSource == osc_cfg_pkg::SRC_FAST_RC && target_ff == $past(initSrc))
    else $error("two-speed start not on fast RC");
  chk_switch_locked: assert property (
    state_ff == osc_cfg_pkg::ST_RUN && !switchOk
    |=> $stable(activeSource) && state_ff == osc_cfg_pkg::ST_RUN)
    else $error("source changed while switching disabled");
  chk_switch_finish: assert property (
    inSwitch && targetReady && !failTake && !wrCtl
    |=> activeSource == $past(target_ff) && !switchReq_ff)
    else $error("switch did not complete");
  chk_pin_crystal: assert property (
    crystalMode |-> !oscPinOe)
    else $error("pin driven in crystal mode");
  chk_pin_function: assert property (
    running && !crystalMode |-> oscPinOe == pinFunction &&
    oscPinIsGpio == !pinFunction)
    else $error("pin function mismatch");
  chk_cycle_clock: assert property (
    oscPinOe ##1 oscPinOe |-> oscPinOut != $past(oscPinOut))
    else $error("cycle clock not half rate");
  chk_lock_one_way: assert property (
    oneWay && ioLock_ff |=> ioLock_ff)
    else $error("one-way lock was released");
  chk_fail_sticky: assert property (
    fail_ff && !wrCtl |=> fail_ff)
    else $error("failure flag lost");
  chk_monitor_off: assert property (
    swMon[1] |-> !failMonitorEnable && !switchEnabled)
    else $error("mode 1x left switching or monitor on");
  chk_read_source: assert property (
    regRd && addrHiZero && addrLo == osc_cfg_pkg::ADDR_CONTROL
    |=> regRdData[osc_cfg_pkg::CTL_CUR_LSB +: 3] == $past(curSrc_ff))
    else $error("current source read wrong");

  cov_two_speed: cover property (
    inSwitch && targetReady && !switchReq_ff);
  cov_soft_switch: cover property (
    state_ff == osc_cfg_pkg::ST_RUN && switchReq_ff && switchOk);
  cov_fail_fallback: cover property (failTake);
  cov_clock_out: cover property (oscPinOe ##1 oscPinOe);
endmodule

// ---- testbench/tb_oscillator_source_config.sv ----
`timescale 1ns/100ps
module tb_oscillator_source_config;
  typedef struct {
    logic [15:0] data;
    logic [15:0] mask;
  } rd_note_t;
  logic clk;
  logic rst;
  logic [15:0] srcSel;
  logic [15:0] oscWord;
  logic [2:0] regAddr;
  logic [15:0] regWrData;
  logic regWr;
  logic regRd;
  logic [15:0] regRdData;
  logic priRdy;
  logic pllLock;
  logic [2:0] activeSource;
  logic [1:0] primaryMode;
  logic primaryEnable;
  logic pllEnable;
  logic [2:0] dozeRatio;
  logic [2:0] frcPostscale;
  logic [4:0] pllPrescale;
  logic [1:0] pllPostscale;
  logic [8:0] pllFeedback;
  logic [5:0] rcTune;
  logic [1:0] auxMode;
  logic [2:0] auxDivide;
  logic cfgReady;
  logic oscPinOut;
  logic failPin;
  logic failMonitorEnable;
  logic switchEnabled;
  logic dozeEnable;
  logic pinSelectWriteOk;
  logic oscPinOe;
  logic oscPinIsGpio;
  logic rdDly;
  logic [15:0] rnd;
  logic [15:0] ow;
  logic [1:0] md;
  logic pinOn;
  int err_count;
  int checked;
  rd_note_t noteQ[$];
  rd_note_t note;

  oscillator_source_config uut (
    .clk(clk), .rst(rst), .srcSelectCfgWord(srcSel), .oscCfgWord(oscWord),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .primaryReadyPin(priRdy),
    .secondaryReadyPin(1'b1), .pllLockPin(pllLock), .clockFailPin(failPin),
    .intEvent(1'b0), .activeSource(activeSource), .primaryMode(primaryMode),
    .primaryEnable(primaryEnable), .pllEnable(pllEnable), .secondaryEnable(),
    .failMonitorEnable(failMonitorEnable), .switchEnabled(switchEnabled),
    .dozeEnable(dozeEnable), .dozeRatio(dozeRatio),
    .frcPostscale(frcPostscale), .pllPrescale(pllPrescale),
    .pllPostscale(pllPostscale), .pllFeedback(pllFeedback), .rcTune(rcTune),
    .auxMode(auxMode), .auxDivide(auxDivide),
    .pinSelectWriteOk(pinSelectWriteOk), .cfgReady(cfgReady),
    .oscPinOut(oscPinOut), .oscPinOe(oscPinOe), .oscPinIsGpio(oscPinIsGpio)
  );

  task automatic fail(input string msg);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic test_done();
    if (noteQ.size() != 0) fail("read expectation left unanswered");
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chkRead(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic chkPort(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("port %h expected %h", got, exp));
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // expected data goes on the queue as the strobe is launched
  task automatic rd(input logic [2:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    noteQ.push_back(rd_note_t'{e & m, m});
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  task automatic boot(input logic [15:0] s, input logic [15:0] o);
    @(posedge clk);
    rst <= 1'b1;
    srcSel <= s;
    oscWord <= o;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // bounded wait; a source switch needs two sync flops plus the state hop
  task automatic waitSrc(input logic [2:0] e, input int bound);
    int n;
    n = 0;
    while (activeSource !== e && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    chkPort(activeSource, e);
    if (n >= bound && bound > 0) test_done();
  endtask

  always @(posedge clk) rdDly <= regRd;
  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rdDly === 1'b1) begin
      if (noteQ.size() == 0) begin
        fail("read data with no expectation");
      end else begin
        note = noteQ.pop_front();
        chkRead(regRdData & note.mask, note.data);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    srcSel = 16'hffff;
    oscWord = 16'hffff;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    priRdy = 1'b1;
    pllLock = 1'b1;
    failPin = 1'b0;
    err_count = 0;
    checked = 0;
    rnd = 16'($urandom(32'h0702971c));
    boot(16'hffff, 16'hffff);
    waitSrc(osc_cfg_pkg::SRC_FAST_RC_DIVN, 0);
    chkPort(3'(switchEnabled), 3'h0);
    chkPort(3'(cfgReady), 3'h1);
    for (int c = 0; c < 8; c++) begin
      md = c[1:0];
      pinOn = c[2];
      ow = {8'hff, c[2:1], 3'b011, pinOn, md};
      boot({8'hff, 5'h0f, c[2:0]}, ow);
      waitSrc(c[2:0], 0);
      rd(osc_cfg_pkg::ADDR_CONTROL, {1'b0, c[2:0], 12'h000}, 16'h7000);
      chkPort(3'(primaryMode), 3'(md));
      chkPort(3'(switchEnabled), 3'(!c[2]));
      chkPort(3'(failMonitorEnable), 3'(c[2:1] == 2'b00));
      // crystal modes own the pin whatever the function bit says
      chkPort(3'(oscPinOe), 3'(pinOn && md != 2'h1 && md != 2'h2));
      if (md == 2'h0 || md == 2'h3) chkPort(3'(oscPinIsGpio), 3'(!pinOn));
    end
    boot(16'hff78, 16'hff5c);
    ow[0] = oscPinOut;
    @(posedge clk);
    #1;
    chkPort(3'(oscPinOut), 3'(!ow[0]));
    rd(osc_cfg_pkg::ADDR_DIVISOR, osc_cfg_pkg::DIVISOR_RESET, 16'hffff);
    rd(osc_cfg_pkg::ADDR_FEEDBACK, 16'h0030, 16'hffff);
    rd(osc_cfg_pkg::ADDR_TUNING, 16'h0000, 16'hffff);
    rd(osc_cfg_pkg::ADDR_AUX, 16'h0000, 16'hffff);
    rd(3'h7, 16'h0000, 16'hffff);
    wr(osc_cfg_pkg::ADDR_DIVISOR, rnd);
    rd(osc_cfg_pkg::ADDR_DIVISOR, rnd, 16'hffdf);
    chkPort(3'(dozeEnable), 3'(rnd[11]));
    chkPort(dozeRatio, rnd[14:12]);
    chkPort(frcPostscale, rnd[10:8]);
    chkPort(3'(pllPostscale), 3'(rnd[7:6]));
    chkPort(pllPrescale[2:0], rnd[2:0]);
    chkPort(3'(pllPrescale[4:3]), 3'(rnd[4:3]));
    wr(osc_cfg_pkg::ADDR_FEEDBACK, ~rnd);
    rd(osc_cfg_pkg::ADDR_FEEDBACK, ~rnd, 16'h01ff);
    chkPort(pllFeedback[2:0], ~rnd[2:0]);
    chkPort(pllFeedback[8:6], ~rnd[8:6]);
    wr(osc_cfg_pkg::ADDR_TUNING, rnd);
    rd(osc_cfg_pkg::ADDR_TUNING, rnd, 16'h003f);
    chkPort(rcTune[2:0], rnd[2:0]);
    chkPort(rcTune[5:3], rnd[5:3]);
    wr(osc_cfg_pkg::ADDR_AUX, rnd);
    rd(osc_cfg_pkg::ADDR_AUX, rnd, 16'h001f);
    chkPort(3'(auxMode), 3'(rnd[1:0]));
    chkPort(auxDivide, rnd[4:2]);
    wr(osc_cfg_pkg::ADDR_SEL_WORD, 16'h0000);
    rd(osc_cfg_pkg::ADDR_SEL_WORD, 16'hff78, 16'hffff);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0301);
    waitSrc(osc_cfg_pkg::SRC_PRIMARY_PLL, 20);
    chkPort(3'(pllEnable), 3'h1);
    chkPort(3'(primaryEnable), 3'h1);
    rd(osc_cfg_pkg::ADDR_CONTROL, 16'h3000, 16'h7001);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0040);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0000);
    #1;
    chkPort(3'(pinSelectWriteOk), 3'h1);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0080);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0181);
    repeat (8) @(posedge clk);
    #1;
    chkPort(activeSource, osc_cfg_pkg::SRC_PRIMARY_PLL);
    boot(16'hff78, 16'hffdc);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0101);
    repeat (8) @(posedge clk);
    #1;
    chkPort(activeSource, osc_cfg_pkg::SRC_FAST_RC);
    // monitor mode 00: a failed primary falls back to fast RC
    boot(16'hff7a, 16'hff1c);
    waitSrc(osc_cfg_pkg::SRC_PRIMARY, 0);
    @(posedge clk);
    failPin <= 1'b1;
    waitSrc(osc_cfg_pkg::SRC_FAST_RC, 8);
    rd(osc_cfg_pkg::ADDR_CONTROL, 16'h0008, 16'h7008);
    failPin <= 1'b0;
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0000);
    rd(osc_cfg_pkg::ADDR_CONTROL, 16'h0000, 16'h0008);
    // two-speed start holds fast RC until the primary reports ready
    @(posedge clk);
    priRdy <= 1'b0;
    boot(16'hfffa, 16'hff7c);
    waitSrc(osc_cfg_pkg::SRC_FAST_RC, 0);
    chkPort(3'(primaryEnable), 3'h1);
    chkPort(3'(pllEnable), 3'h0);
    @(posedge clk);
    priRdy <= 1'b1;
    waitSrc(osc_cfg_pkg::SRC_PRIMARY, 12);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0040);
    wr(osc_cfg_pkg::ADDR_CONTROL, 16'h0000);
    #1;
    chkPort(3'(pinSelectWriteOk), 3'h0);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule
